// ===== pkg/abmu_consts.svh
// Offsets, field positions, reset values and counts of the math unit.
`ifndef ABMU_CONSTS_SVH
`define ABMU_CONSTS_SVH

`define ABMU_OFF_ACC 12'h000
`define ABMU_OFF_MEM 12'h004
`define ABMU_OFF_CMD 12'h008
`define ABMU_OFF_STAT 12'h00c

`define ABMU_CMD_OP_LSB 0
`define ABMU_CMD_CNT_LSB 8
`define ABMU_CMD_SRC_BIT 16
`define ABMU_STAT_BUSY_BIT 8

`define ABMU_FLG_ZERO 0
`define ABMU_FLG_NEG 1
`define ABMU_FLG_VALID 2
`define ABMU_FLG_SIGN 3
`define ABMU_FLG_FMT 4
`define ABMU_FLG_RANGE 5

`define ABMU_RST_ACC 32'h0000_0000
`define ABMU_RST_MEM 16'h0000
`define ABMU_RST_FLAGS 6'h00

`define ABMU_SHIFT_MAX 16'h0020
`define ABMU_ROOT_LAST 6'h1f
`define ABMU_VECT_LAST 6'h1e

`define ABMU_FP_BIAS 127
`define ABMU_ANGLE_FRAC 30
`define ABMU_ATAN_SMALL_EXP -12
`define ABMU_ATAN_BIG_EXP 24
`define ABMU_HALF_PI_FP 32'h3fc9_0fdb
`define ABMU_PI_FP 32'h4049_0fdb
`define ABMU_PI_Q30 34'h0_c90f_daa2
`define ABMU_ONE_Q60 64'h1000_0000_0000_0000

`endif

// ===== pkg/abmu_pkg.sv
// Types shared by the accumulator bit and math unit.
package abmu_pkg;

  typedef enum logic [3:0] {
    inverse_cosine_op = 4'h0,
    inverse_tangent_op = 4'h1,
    square_root_real_op = 4'h2,
    increment_word_op = 4'h3,
    decrement_word_op = 4'h4,
    shift_left_op = 4'h5,
    shift_right_op = 4'h6,
    rotate_left_op = 4'h7,
    rotate_right_op = 4'h8,
    encode_op = 4'h9,
    decode_op = 4'ha,
    bcd_to_binary_op = 4'hb,
    bitwise_complement_op = 4'hc
  } abmu_op_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_root = 2'b01,
    st_vector = 2'b10
  } abmu_state_e;

  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] mem;
    logic [5:0] flags;
    abmu_state_e st;
    abmu_op_e op;
    logic [5:0] it;
    logic [63:0] rad;
    logic [31:0] root;
    logic [35:0] rem;
    logic signed [51:0] cx;
    logic signed [51:0] cy;
    logic signed [33:0] cz;
    logic xneg;
    logic signed [9:0] p;
    logic ack;
    logic [31:0] prdata;
    logic pslverr;
  } abmu_state_s;

endpackage

// ===== design/abmu_core.sv
// Accumulator datapath with real math, bit operations and an APB slave.
`include "abmu_consts.svh"

// Operation
// - Arc cosine replaces the real accumulator with a real result.
// - Arc tangent replaces the real accumulator with a real result.
// - Square root replaces the real accumulator with a real result.
// - Decrement subtracts one from the memory word and writes it back.
// - Increment adds one to the memory word and writes it back.
// - Zero flag is set on a zero result, cleared otherwise.
// - Each flag holds only until the next operation updating it.
// - Shift left by count, zeros enter low, top bits are lost.
// - Shift right by count, zeros enter high, low bits are lost.
// - Rotate left by count, top bits re-enter at the bottom.
// - Rotate right by count, low bits re-enter at the top.
// - Encode returns the index of the set bit; bit 31 gives 1f.
// - Several bits set: lowest index returned and range flag raised.
// - Zero or bit 0 input gives zero; zero input raises range flag.
// - Decode sets the accumulator bit named by a five-bit index.
// - Decode indices above 31 are reduced modulo 32.
// - Packed BCD accumulator is converted to plain binary.
// - Complement inverts all 32 accumulator bits.
// - Real math updates zero, sign, valid, error and range flags.
module abmu_core
  import abmu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  abmu_state_s r;
  abmu_state_s next_r;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Arc tangent of two to the minus i, as Q30 angle.
  function automatic logic signed [33:0] atan_tab(input logic [5:0] i);
    case (i)
      6'd0: atan_tab = 34'sh0_3243_f6a8;
      6'd1: atan_tab = 34'sh0_1dac_6705;
      6'd2: atan_tab = 34'sh0_0fad_bafc;
      6'd3: atan_tab = 34'sh0_07f5_6ea6;
      6'd4: atan_tab = 34'sh0_03fe_ab76;
      6'd5: atan_tab = 34'sh0_01ff_d55b;
      6'd6: atan_tab = 34'sh0_00ff_faaa;
      6'd7: atan_tab = 34'sh0_007f_ff55;
      6'd8: atan_tab = 34'sh0_003f_ffea;
      6'd9: atan_tab = 34'sh0_001f_fffd;
      6'd10: atan_tab = 34'sh0_000f_ffff;
      default: atan_tab = 34'sh0_4000_0000 >>> i;
    endcase
  endfunction

  // Turns mag times two to the p into a single-precision value.
  // The mantissa is truncated, so results may sit one ulp low.
  function automatic logic [31:0] pack_fp(input logic s,
                                          input logic [63:0] mag,
                                          input int p);
    int lead;
    int ex;
    logic [63:0] sh;
    lead = -1;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) begin
        lead = i;
      end
    end
    ex = lead + p + `ABMU_FP_BIAS;
    sh = (lead < 0) ? 64'h0 : mag << (63 - lead);
    if (lead < 0 || ex <= 0) begin
      pack_fp = 32'h0;
    end else if (ex >= 255) begin
      pack_fp = {s, 8'hff, 23'h0};
    end else begin
      pack_fp = {s, ex[7:0], sh[62:40]};
    end
  endfunction
  function automatic logic [5:0] fp_flags(input logic [31:0] res,
                                          input logic serr,
                                          input logic bfmt,
                                          input logic rng);
    logic z;
    z = (res[30:0] == 31'h0);
    fp_flags = 6'h0;
    fp_flags[`ABMU_FLG_ZERO] = z;
    fp_flags[`ABMU_FLG_NEG] = res[31] & ~z;
    fp_flags[`ABMU_FLG_VALID] = (res[30:23] != 8'hff);
    fp_flags[`ABMU_FLG_SIGN] = serr;
    fp_flags[`ABMU_FLG_FMT] = bfmt;
    fp_flags[`ABMU_FLG_RANGE] = rng;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic busy;
    logic hit;
    logic [31:0] wmask;
    logic [15:0] raw;
    logic [5:0] cnt;
    logic [7:0] bexp;
    logic [23:0] man;
    int e;
    logic [63:0] xq;
    logic [61:0] sq;
    logic [35:0] rm;
    logic [35:0] tr;
    logic [31:0] nroot;
    logic signed [51:0] dx;
    logic signed [51:0] dy;
    logic signed [33:0] nz;
    logic [33:0] amag;
    logic [31:0] res;
    logic [4:0] idx;
    logic [31:0] bin;
    busy = (r.st != st_idle);
    hit = 1'b0;
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    raw = 16'h0;
    cnt = 6'h0;
    bexp = r.acc[30:23];
    man = {1'b1, r.acc[22:0]};
    e = int'(bexp) - `ABMU_FP_BIAS;
    xq = 64'h0;
    sq = 62'h0;
    rm = 36'h0;
    tr = 36'h0;
    nroot = 32'h0;
    dx = 52'sh0;
    dy = 52'sh0;
    nz = 34'sh0;
    amag = 34'h0;
    res = 32'h0;
    idx = 5'h0;
    bin = 32'h0;
    next_r = r;
    next_r.ack = 1'b0;

    // Setup of the answer: data and error are latched one cycle early
    // so that prdata comes straight from flip-flops and pslverr from a flip-flop gated by pready.
    if (psel && penable && !r.ack) begin
      next_r.ack = 1'b1;
      next_r.prdata = 32'h0;
      next_r.pslverr = 1'b0;
      case (paddr)
        `ABMU_OFF_ACC: begin
          next_r.prdata = r.acc;
          next_r.pslverr = pwrite & busy;
        end
        `ABMU_OFF_MEM: begin
          next_r.prdata = {16'h0, r.mem};
          next_r.pslverr = pwrite & busy;
        end
        `ABMU_OFF_CMD: begin
          next_r.pslverr = pwrite & (busy | (pwdata[3:0] > 4'hc));
        end
        `ABMU_OFF_STAT: begin
          next_r.prdata[`ABMU_STAT_BUSY_BIT] = busy;
          next_r.prdata[5:0] = r.flags;
          next_r.pslverr = pwrite;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // Writes take effect on the edge where pready is seen high.
    if (psel && penable && r.ack && pwrite && !r.pslverr) begin
      case (paddr)
        `ABMU_OFF_ACC: next_r.acc = (r.acc & ~wmask) | (pwdata & wmask);
        `ABMU_OFF_MEM: next_r.mem = (r.mem & ~wmask[15:0]) |
                                    (pwdata[15:0] & wmask[15:0]);
        `ABMU_OFF_CMD: hit = 1'b1;
        default: ;
      endcase
    end

    if (hit) begin
      raw = pwdata[`ABMU_CMD_SRC_BIT] ? r.mem :
            {10'h0, pwdata[`ABMU_CMD_CNT_LSB +: 6]};
      cnt = (raw > `ABMU_SHIFT_MAX) ? 6'd32 : raw[5:0];
      next_r.op = abmu_op_e'(pwdata[`ABMU_CMD_OP_LSB +: 4]);
      next_r.it = 6'h0;
      next_r.root = 32'h0;
      next_r.rem = 36'h0;
      next_r.cz = 34'sh0;
      case (abmu_op_e'(pwdata[`ABMU_CMD_OP_LSB +: 4]))
        square_root_real_op: begin
          if (bexp == 8'hff) begin
            next_r.flags = fp_flags(r.acc, 1'b0, 1'b1, 1'b0);
          end else if (bexp == 8'h00) begin
            next_r.acc = 32'h0;
            next_r.flags = fp_flags(32'h0, 1'b0, 1'b0, 1'b0);
          end else if (r.acc[31]) begin
            next_r.flags = fp_flags(r.acc, 1'b1, 1'b0, 1'b0);
          end else begin
            // Radicand exponent is kept even so it halves exactly.
            next_r.rad = e[0] ? {man, 40'h0} : {1'b0, man, 39'h0};
            next_r.p = e[0] ? 10'((e - 63) / 2) : 10'((e - 62) / 2);
            next_r.st = st_root;
          end
        end
        inverse_cosine_op: begin
          if (bexp == 8'hff) begin
            next_r.flags = fp_flags(r.acc, 1'b0, 1'b1, 1'b0);
          end else if (bexp > 8'd127 ||
                       (bexp == 8'd127 && r.acc[22:0] != 23'h0)) begin
            next_r.flags = fp_flags(r.acc, 1'b0, 1'b0, 1'b1);
          end else begin
            xq = (bexp == 8'h00) ? 64'h0 :
                 (e >= -7) ? ({40'h0, man} << (e + 7)) :
                 ({40'h0, man} >> (-7 - e));
            sq = xq[30:0] * xq[30:0];
            next_r.rad = `ABMU_ONE_Q60 - {2'b00, sq};
            next_r.cx = 52'(xq);
            next_r.xneg = r.acc[31];
            next_r.st = st_root;
          end
        end
        inverse_tangent_op: begin
          if (bexp == 8'hff) begin
            next_r.flags = fp_flags(r.acc, 1'b0, 1'b1, 1'b0);
          end else if (e >= `ABMU_ATAN_BIG_EXP) begin
            next_r.acc = {r.acc[31], 31'(`ABMU_HALF_PI_FP)};
            next_r.flags = fp_flags(next_r.acc, 1'b0, 1'b0, 1'b0);
          end else if (bexp == 8'h00 || e < `ABMU_ATAN_SMALL_EXP) begin
            // Below this size the arc tangent equals its argument.
            next_r.acc = (bexp == 8'h00) ? 32'h0 : r.acc;
            next_r.flags = fp_flags(next_r.acc, 1'b0, 1'b0, 1'b0);
          end else begin
            next_r.cx = 52'sh1 << (23 - e);
            next_r.cy = 52'(man);
            next_r.xneg = r.acc[31];
            next_r.st = st_vector;
          end
        end
        increment_word_op: begin
          next_r.mem = r.mem + 16'h1;
          next_r.flags[`ABMU_FLG_ZERO] = (r.mem == 16'hffff);
        end
        decrement_word_op: begin
          next_r.mem = r.mem - 16'h1;
          next_r.flags[`ABMU_FLG_ZERO] = (r.mem == 16'h0001);
        end
        shift_left_op: next_r.acc = r.acc << cnt;
        shift_right_op: next_r.acc = r.acc >> cnt;
        rotate_left_op: next_r.acc =
            32'(({r.acc, r.acc} << cnt) >> 32);
        rotate_right_op: next_r.acc = 32'({r.acc, r.acc} >> cnt);
        encode_op: begin
          for (int i = 31; i >= 0; i--) begin
            if (r.acc[i]) begin
              idx = 5'(i);
            end
          end
          next_r.acc = {27'h0, idx};
          next_r.flags[`ABMU_FLG_RANGE] = (r.acc == 32'h0) ||
              ((r.acc & (r.acc - 32'h1)) != 32'h0);
        end
        decode_op: next_r.acc = 32'h1 << r.acc[4:0];
        bcd_to_binary_op: begin
          for (int i = 7; i >= 0; i--) begin
            bin = 32'(bin * 32'd10) + {28'h0, r.acc[4 * i +: 4]};
          end
          next_r.acc = bin;
        end
        bitwise_complement_op: next_r.acc = ~r.acc;
        default: ;
      endcase
    end

    // Iterative engine: restoring square root, then CORDIC vectoring.
    case (r.st)
      st_root: begin
        rm = {r.rem[33:0], r.rad[63:62]};
        tr = {2'b00, r.root, 2'b01};
        if (rm >= tr) begin
          next_r.rem = rm - tr;
          nroot = {r.root[30:0], 1'b1};
        end else begin
          next_r.rem = rm;
          nroot = {r.root[30:0], 1'b0};
        end
        next_r.root = nroot;
        next_r.rad = {r.rad[61:0], 2'b00};
        next_r.it = r.it + 6'h1;
        if (r.it == `ABMU_ROOT_LAST) begin
          next_r.it = 6'h0;
          if (r.op == square_root_real_op) begin
            res = pack_fp(1'b0, {32'h0, nroot}, int'(r.p));
            next_r.acc = res;
            next_r.flags = fp_flags(res, 1'b0, 1'b0, 1'b0);
            next_r.st = st_idle;
          end else if (nroot == 32'h0) begin
            res = r.xneg ? `ABMU_PI_FP : 32'h0;
            next_r.acc = res;
            next_r.flags = fp_flags(res, 1'b0, 1'b0, 1'b0);
            next_r.st = st_idle;
          end else begin
            next_r.cy = 52'(nroot);
            next_r.st = st_vector;
          end
        end
      end
      st_vector: begin
        dx = r.cx >>> r.it;
        dy = r.cy >>> r.it;
        if (!r.cy[51]) begin
          next_r.cx = r.cx + dy;
          next_r.cy = r.cy - dx;
          nz = r.cz + atan_tab(r.it);
        end else begin
          next_r.cx = r.cx - dy;
          next_r.cy = r.cy + dx;
          nz = r.cz - atan_tab(r.it);
        end
        next_r.cz = nz;
        next_r.it = r.it + 6'h1;
        if (r.it == `ABMU_VECT_LAST) begin
          amag = nz[33] ? 34'h0 : 34'(nz);
          if (r.op == inverse_cosine_op && r.xneg) begin
            amag = `ABMU_PI_Q30 - amag;
          end
          res = pack_fp((r.op == inverse_tangent_op) & r.xneg,
                        {30'h0, amag}, -`ABMU_ANGLE_FRAC);
          next_r.acc = res;
          next_r.flags = fp_flags(res, 1'b0, 1'b0, 1'b0);
          next_r.st = st_idle;
          next_r.it = 6'h0;
        end
      end
      default: ;
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.acc <= `ABMU_RST_ACC;
      r.mem <= `ABMU_RST_MEM;
      r.flags <= `ABMU_RST_FLAGS;
    end else begin
      r <= next_r;
    end
  end

  assign pready = psel & penable & r.ack;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr & pready;

endmodule

// ===== bench/abmu_props.sv
// Concurrent checks on the APB ports of the math unit.
module abmu_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Shadow of the accumulator, trusted only while predictable.
  logic [31:0] shadow;
  logic known;
  logic done;
  assign done = pready && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= 32'h0000_0000;
      known <= 1'b1;
    end else if (done && pwrite && paddr == 12'h000) begin
      shadow <= pwdata;
      known <= (pstrb == 4'hf);
    end else if (done && pwrite && paddr == 12'h008) begin
      shadow <= ~shadow;
      known <= known && (pwdata[3:0] == 4'hc);
    end
  end
  // ==========================================================
  // Properties.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  chk_ready_gated: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not in the second access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held for two cycles");
  chk_err_gated: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_cmd_reads: assert property (pready && !pwrite && paddr == 12'h008
    |-> prdata == 32'h0000_0000) else $error("command read not zero");
  chk_mem_upper: assert property (pready && !pwrite && paddr == 12'h004
    |-> prdata[31:16] == 16'h0000) else $error("memory word upper bits set");
  chk_refuse_addr: assert property (pready && (paddr > 12'h00c
    || paddr[1:0] != 2'b00 || (pwrite && paddr == 12'h00c)) |-> pslverr)
    else $error("bad address not refused");
  chk_read_ok: assert property (pready && !pwrite && paddr <= 12'h00c
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped read refused");
  chk_bad_opcode: assert property (pready && pwrite && paddr == 12'h008
    && pwdata[3:0] > 4'hc |-> pslverr) else $error("bad opcode accepted");
  chk_acc_invert: assert property (
    done && !pwrite && paddr == 12'h000 && known |-> prdata == shadow)
    else $error("accumulator not as predicted");
endmodule

bind abmu_core abmu_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== bench/abmu_apb_master.sv
// APB master model standing in for the instruction sequencer.
module abmu_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end
  // ==========================================================
  // One transfer; released address and data lines show the inverse so stale data is unseen.
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Byte lanes for the following writes; change only between transfers.
  task automatic strobe(input logic [3:0] s);
    pstrb <= s;
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking testbench of the math unit over APB.
`include "abmu_consts.svh"
module tb_top
  import abmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r, st;
  logic [3:0] pstrb;
  int bad_count = 0;
  int n_tests = 0;
  int cn[3] = '{1, 7, 32};
  logic [31:0] tin[10] = '{32'h8000_0000, 32'h0000_0050, 32'h0000_0001,
    32'h0000_0000, 32'h0000_000f, 32'h0000_002f, 32'hffff_ffe0,
    32'hc080_0000, 32'h4000_0000, 32'h7fc0_0000};
  logic [31:0] tex[7] = '{32'h1f, 32'h4, 32'h0, 32'h0, 32'h8000, 32'h8000,
    32'h1};
  always #20 pclk = ~pclk;
  abmu_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  abmu_apb_master m (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================================
  // Access and comparison helpers.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q, e);
    chk(32'(e), 32'h0);
  endtask
  task automatic op(input logic [31:0] acc, input logic [31:0] cmd);
    wr(`ABMU_OFF_ACC, acc);
    wr(`ABMU_OFF_CMD, cmd);
    do m.xfer(1'b0, `ABMU_OFF_STAT, 32'h0, st, e); while (st[8] !== 1'b0);
    m.xfer(1'b0, `ABMU_OFF_ACC, 32'h0, r, e);
  endtask
  task automatic near(input logic [31:0] x);
    chk(32'((r > x ? r - x : x - r) <= 32'h10), 32'h1);
  endtask
  function automatic logic [31:0] cmdw(input logic [3:0] o,
    input logic [5:0] c, input logic s);
    return {15'h0000, s, 2'h0, c, 4'h0, o};
  endfunction
  function automatic logic [31:0] sh(input logic [3:0] o,
    input logic [31:0] a, input int n);
    logic [63:0] d;
    d = {a, a};
    case (o)
      shift_left_op: return (n >= 32) ? 32'h0 : a << n;
      shift_right_op: return (n >= 32) ? 32'h0 : a >> n;
      rotate_left_op: return d[63 - (n % 32) -: 32];
      default: return d[(n % 32) +: 32];
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Test sequence.
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m.xfer(1'b0, 12'(i * 4), 32'h0, r, e);
      chk(r, 32'h0);
    end
    wr(`ABMU_OFF_ACC, 32'hffff_ffff);
    m.strobe(4'h3);
    wr(`ABMU_OFF_ACC, 32'h0000_1234);
    m.strobe(4'hf);
    m.xfer(1'b0, `ABMU_OFF_ACC, 32'h0, r, e);
    chk(r, 32'hffff_1234);
    for (int o = 5; o <= 8; o++) begin
      foreach (cn[i]) begin
        op(32'ha5c3_0f81, cmdw(4'(o), 6'(cn[i]), 1'b0));
        chk(r, sh(4'(o), 32'ha5c3_0f81, cn[i]));
      end
      wr(`ABMU_OFF_MEM, 32'h0000_0003);
      op(32'ha5c3_0f81, cmdw(4'(o), 6'h00, 1'b1));
      chk(r, sh(4'(o), 32'ha5c3_0f81, 3));
    end
    wr(`ABMU_OFF_MEM, 32'h0000_ffff);
    op(32'h0000_0001, cmdw(increment_word_op, 6'h00, 1'b0));
    chk(st, 32'h1);
    m.xfer(1'b0, `ABMU_OFF_MEM, 32'h0, r, e);
    chk(r, 32'h0);
    op(32'h0000_0001, cmdw(decrement_word_op, 6'h00, 1'b0));
    chk(st, 32'h0);
    m.xfer(1'b0, `ABMU_OFF_MEM, 32'h0, r, e);
    chk(r, 32'h0000_ffff);
    for (int i = 0; i < 7; i++) begin
      op(tin[i], cmdw(i < 4 ? encode_op : decode_op, 6'h00, 1'b0));
      chk(r, tex[i]);
      if (i < 4) chk(32'(st[5]), 32'(i == 1 || i == 3));
    end
    op(32'h1234_5678, cmdw(bcd_to_binary_op, 6'h00, 1'b0));
    chk(r, 32'h00bc_614e);
    op(32'h0f0f_a55a, cmdw(bitwise_complement_op, 6'h00, 1'b0));
    chk(r, 32'hf0f0_5aa5);
    op(32'h4180_0000, cmdw(square_root_real_op, 6'h00, 1'b0));
    near(32'h4080_0000);
    chk(32'(st[2]), 32'h1);
    op(32'h0000_0000, cmdw(inverse_cosine_op, 6'h00, 1'b0));
    near(32'h3fc9_0fdb);
    op(32'hbf80_0000, cmdw(inverse_cosine_op, 6'h00, 1'b0));
    near(32'h4049_0fdb);
    op(32'h3f80_0000, cmdw(inverse_tangent_op, 6'h00, 1'b0));
    near(32'h3f49_0fdb);
    for (int i = 7; i < 10; i++) begin
      op(tin[i], cmdw(i == 8 ? inverse_cosine_op : square_root_real_op,
        6'h00, 1'b0));
      chk(r, tin[i]);
      chk(32'(st[i == 7 ? 3 : i == 8 ? 5 : 4]), 32'h1);
    end
    m.xfer(1'b1, `ABMU_OFF_STAT, 32'h0, q, e);
    chk(32'(e), 32'h1);
    m.xfer(1'b1, 12'h010, 32'h0, q, e);
    chk(32'(e), 32'h1);
    m.xfer(1'b1, `ABMU_OFF_CMD, 32'h0000_000d, q, e);
    chk(32'(e), 32'h1);
    wr(`ABMU_OFF_ACC, 32'h4180_0000);
    wr(`ABMU_OFF_CMD, cmdw(square_root_real_op, 6'h00, 1'b0));
    m.xfer(1'b1, `ABMU_OFF_ACC, 32'h0, q, e);
    chk(32'(e), 32'h1);
    end_sim();
  end
endmodule
